// [dv/sgw_board_model.sv]
/*
  board side of the block: strap resistors, pulls, modem ring, link power.
  assumes: pin outputs and enables come straight from the design.
*/
`timescale 1ns/1ps
module sgw_board_model (
  input  wire logic [3:0] i_strap_c0,
  input  wire logic [3:0] i_strap_c1,
  input  wire logic [7:0] i_strap_gpio,
  input  wire logic       i_strap_en,
  input  wire logic       i_ring_on,
  input  wire logic       i_l2_on,
  input  wire logic [3:0] i_c0_out,
  input  wire logic [3:0] i_c1_out,
  input  wire logic [1:0] i_mode_oe,
  input  wire logic [7:0] i_gpio_out,
  input  wire logic [7:0] i_gpio_oe,
  output logic      [3:0] o_c0_pin,
  output logic      [3:0] o_c1_pin,
  output logic      [7:0] o_gpio_pin,
  output logic            o_ring_n,
  output logic            o_l2
);
  // ****
  // pin resolution
  // ****
  logic [3:0] c0_brd;
  logic [3:0] c1_brd;
  logic [7:0] g_brd;
  // unstrapped: pulled down, gpio 2 pulled up
  assign c0_brd = i_strap_en ? i_strap_c0 : 4'h0;
  assign c1_brd = i_strap_en ? i_strap_c1 : 4'h0;
  assign g_brd = i_strap_en ? i_strap_gpio : 8'h04;
  assign o_c0_pin = i_mode_oe[0] ? i_c0_out : c0_brd;
  assign o_c1_pin = i_mode_oe[1] ? i_c1_out : c1_brd;
  assign o_gpio_pin = (i_gpio_oe & i_gpio_out) | (~i_gpio_oe & g_brd);
  assign o_ring_n = ~i_ring_on;
  assign o_l2 = i_l2_on;
endmodule  // sgw_board_model

// [dv/sgw_strap_gpio_wake_chk.sv]
/*
  assertions on the top ports of the strap, pin and wake block.
  assumes: bound to sgw_strap_gpio_wake, one clock.
*/
`timescale 1ns/1ps
module sgw_strap_gpio_wake_chk (
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic       i_awvalid,
  input wire logic       o_awready,
  input wire logic       i_wvalid,
  input wire logic       o_wready,
  input wire logic       o_bvalid,
  input wire logic       i_arvalid,
  input wire logic       o_arready,
  input wire logic       o_rvalid,
  input wire logic [3:0] o_chan2_xcvr_mode_sel,
  input wire logic [1:0] o_mode_sel_oe,
  input wire logic [7:0] o_gpio_oe,
  input wire logic       i_ring_indicate_n,
  input wire logic       i_link_in_l2,
  input wire logic       o_wake_n,
  input wire logic       o_straps_valid,
  input wire logic [3:0] o_tx_current_level,
  input wire logic [3:0] o_equalization_level,
  input wire logic [1:0] o_rx_termination_adjust
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // ****
  // assertions
  // ****
  a_wake_on_ring: assert property ((i_link_in_l2 && !i_ring_indicate_n) [*4] |-> !o_wake_n)
    else $error("wake not asserted on ring in L2");
  a_wake_off_l2: assert property ((!i_link_in_l2) [*4] |-> o_wake_n)
    else $error("wake asserted outside L2");
  a_strap_stable: assert property (o_straps_valid && $past(o_straps_valid) |->
    $stable({o_tx_current_level, o_equalization_level, o_rx_termination_adjust}))
    else $error("captured straps changed");
  a_strap_valid_stays: assert property (o_straps_valid |=> o_straps_valid)
    else $error("strap valid dropped");
  a_oe_before_strap: assert property (!o_straps_valid |->
    (o_gpio_oe == 8'h00) && (o_mode_sel_oe == 2'h0))
    else $error("pin driven before strap capture");
  a_mode_bus_write: assert property ($changed(o_chan2_xcvr_mode_sel) |->
    $past(o_bvalid) && !$past(o_bvalid, 2))
    else $error("mode bus changed without write");
  a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |=> ##1 o_bvalid)
    else $error("write response late");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read response late");
  c_wake: cover property (!o_wake_n);
  c_strap: cover property ($rose(o_straps_valid));
  c_mode: cover property ($changed(o_chan2_xcvr_mode_sel));
endmodule  // sgw_strap_gpio_wake_chk

bind sgw_strap_gpio_wake sgw_strap_gpio_wake_chk chk_u (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rvalid(o_rvalid), .o_chan2_xcvr_mode_sel(o_chan2_xcvr_mode_sel),
  .o_mode_sel_oe(o_mode_sel_oe), .o_gpio_oe(o_gpio_oe), .i_ring_indicate_n(i_ring_indicate_n),
  .i_link_in_l2(i_link_in_l2), .o_wake_n(o_wake_n), .o_straps_valid(o_straps_valid),
  .o_tx_current_level(o_tx_current_level), .o_equalization_level(o_equalization_level),
  .o_rx_termination_adjust(o_rx_termination_adjust));

// [dv/sgw_strap_gpio_wake_tb.sv]
/*
  self-checking bench of the strap, pin and wake block.
  assumes: board model on the pins, axi4-lite master tasks here.
*/
`timescale 1ns/1ps
`include "sgw_consts.svh"
module sgw_strap_gpio_wake_tb;
  import sgw_pkg::*;
  logic        clk, rst_n, awv, wv, bry, arv, rry, s_en, ring, l2;
  logic        awr, wr, bv, arr, rv, ring_n, l2_pin, lod, hid, phy, org, sv, wake_n, irq;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd;
  logic [3:0]  ws, s_c0, s_c1, c0_pin, c1_pin, m0, m1, m2, m3, txl, eql;
  logic [7:0]  s_g, g_pin, g_o, g_oe;
  logic [1:0]  br, rr, moe, rxt, txt;
  int          err_count, checked;

  sgw_strap_gpio_wake dut_u (
    .i_clk(clk), .i_reset_n(rst_n), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr),
    .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv), .o_wready(wr), .o_bresp(br), .o_bvalid(bv),
    .i_bready(bry), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rd),
    .o_rresp(rr), .o_rvalid(rv), .i_rready(rry), .i_chan0_xcvr_mode_sel(c0_pin),
    .i_chan1_xcvr_mode_sel(c1_pin), .o_chan0_xcvr_mode_sel(m0), .o_chan1_xcvr_mode_sel(m1),
    .o_chan2_xcvr_mode_sel(m2), .o_chan3_xcvr_mode_sel(m3), .o_mode_sel_oe(moe),
    .i_gpio(g_pin), .o_gpio(g_o), .o_gpio_oe(g_oe), .i_ring_indicate_n(ring_n),
    .i_link_in_l2(l2_pin), .o_tx_current_level(txl), .o_equalization_level(eql),
    .o_low_drive_strap(lod), .o_high_drive_strap(hid), .o_phy_test_strap(phy),
    .o_eeprom_word_org_strap(org), .o_rx_termination_adjust(rxt),
    .o_tx_termination_adjust(txt), .o_straps_valid(sv), .o_wake_n(wake_n), .o_irq(irq));

  sgw_board_model brd_u (
    .i_strap_c0(s_c0), .i_strap_c1(s_c1), .i_strap_gpio(s_g), .i_strap_en(s_en),
    .i_ring_on(ring), .i_l2_on(l2), .i_c0_out(m0), .i_c1_out(m1), .i_mode_oe(moe),
    .i_gpio_out(g_o), .i_gpio_oe(g_oe), .o_c0_pin(c0_pin), .o_c1_pin(c1_pin),
    .o_gpio_pin(g_pin), .o_ring_n(ring_n), .o_l2(l2_pin));

  // ****
  // bus and compare tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask

  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] resp);
    int   n;
    logic got;
    n = 0;
    got = 1'b0;
    awa <= a; awv <= 1'b1; wd <= d; ws <= s; wv <= 1'b1; bry <= 1'b1;
    while (!got && n < 64) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (bv) begin
        bry <= 1'b0;
        resp = br;
        got = 1'b1;
      end
      n++;
    end
    @(posedge clk);
    chk("write done", 1'b1, got);
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    int   n;
    logic got;
    n = 0;
    got = 1'b0;
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    while (!got && n < 64) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        rry <= 1'b0;
        d = rd;
        resp = rr;
        got = 1'b1;
      end
      n++;
    end
    @(posedge clk);
    chk("read done", 1'b1, got);
  endtask

  // ****
  // scenarios
  // ****
  task automatic strap_case(input logic [3:0] c0, input logic [3:0] c1, input logic [7:0] g,
                            input logic en);
    logic [15:0] exp;
    exp = {c1[2:0], c0[3], g[2:0], c1[3], c0[2], c0[1], c0[0], g[7], g[6:5], g[4:3]};
    s_c0 <= c0; s_c1 <= c1; s_g <= g; s_en <= en; rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int n = 0; n < 40 && sv !== 1'b1; n++) @(posedge clk);
    chk("straps valid", 1'b1, sv);
    chk("straps", exp, {txl, eql, lod, phy, hid, org, rxt, txt});
    s_c0 <= ~c0; s_c1 <= ~c1; s_g <= ~g; s_en <= 1'b1;
    repeat (10) @(posedge clk);
    chk("straps held", exp, {txl, eql, lod, phy, hid, org, rxt, txt});
  endtask

  task automatic gpio_case();
    logic [1:0] r;
    logic [31:0] d;
    logic [7:0] oe;
    for (int i = 0; i < 2; i++) begin
      oe = i ? 8'h0f : 8'hf0;
      axw(`SGW_OFF_GPIO_OE, {24'h000000, oe}, 4'h1, r);
      axw(`SGW_OFF_GPIO_OUT, 32'h000000a5, 4'h1, r);
      repeat (3) @(posedge clk);
      axr(`SGW_OFF_GPIO_IN, d, r);
      chk("gpio_oe", oe, g_oe);
      chk("gpio_out", 8'ha5, g_o);
      chk("gpio_in", (8'ha5 & oe) | (s_g & ~oe), d);
    end
  endtask

  task automatic mode_case();
    logic [1:0] r;
    chk("mode_oe", 2'h3, moe);
    axw(`SGW_OFF_MODE_SEL, 32'h00004321, 4'h3, r);
    chk("mode_sel", 16'h4321, {m3, m2, m1, m0});
  endtask

  task automatic wake_case();
    logic [1:0] r;
    logic [31:0] d;
    axw(`SGW_OFF_IRQ_MASK, 32'h0, 4'h1, r);
    ring <= 1'b1;
    repeat (8) @(posedge clk);
    chk("wake outside l2", 1'b1, wake_n);
    ring <= 1'b0;
    repeat (4) @(posedge clk);
    axw(`SGW_OFF_IRQ_STAT, 32'h3, 4'h1, r);
    l2 <= 1'b1;
    ring <= 1'b1;
    for (int n = 0; n < 8 && wake_n !== 1'b0; n++) @(posedge clk);
    chk("wake on ring", 1'b0, wake_n);
    axr(`SGW_OFF_IRQ_STAT, d, r);
    chk("irq stat", 32'h3, d);
    chk("irq masked", 1'b0, irq);
    axw(`SGW_OFF_IRQ_MASK, 32'h3, 4'h1, r);
    repeat (2) @(posedge clk);
    chk("irq on", 1'b1, irq);
    ring <= 1'b0;
    repeat (4) @(posedge clk);
    axw(`SGW_OFF_CTRL, 32'h2, 4'h1, r);
    axw(`SGW_OFF_IRQ_STAT, 32'h3, 4'h1, r);
    repeat (2) @(posedge clk);
    chk("wake released", 1'b1, wake_n);
    chk("irq off", 1'b0, irq);
    l2 <= 1'b0;
  endtask

  task automatic bus_case();
    logic [1:0] r;
    logic [31:0] d;
    axr(12'h020, d, r);
    chk("rresp", 2'h2, r);
    chk("rdata", 32'h0, d);
    axw(12'h024, 32'h1, 4'hf, r);
    chk("bresp", 2'h2, r);
  endtask

  task automatic summarize();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("[FAIL] watchdog expected done seen hang");
    summarize();
  end

  initial begin
    rst_n = 1'b0; awv = 1'b0; wv = 1'b0; bry = 1'b0; arv = 1'b0; rry = 1'b0;
    awa = 12'h000; ara = 12'h000; wd = 32'h0; ws = 4'h0; s_c0 = 4'h0; s_c1 = 4'h0;
    s_g = 8'h04; s_en = 1'b0; ring = 1'b0; l2 = 1'b0; err_count = 0; checked = 0;
    @(posedge clk);
    strap_case(4'h0, 4'h0, 8'h04, 1'b0);
    strap_case(4'ha, 4'h5, 8'h96, 1'b1);
    strap_case(4'h5, 4'ha, 8'h69, 1'b1);
    gpio_case();
    mode_case();
    wake_case();
    bus_case();
    summarize();
  end
endmodule  // sgw_strap_gpio_wake_tb

// [hdl/sgw_consts.svh]
/*
  offsets, field positions, reset values and timing counts of the
  strap, pin and wake block.
  assumes: included by bare name from hdl/ files.
*/
`ifndef SGW_CONSTS_SVH
`define SGW_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define SGW_OFF_GPIO_OUT     12'h000
`define SGW_OFF_GPIO_OE      12'h004
`define SGW_OFF_GPIO_IN      12'h008
`define SGW_OFF_MODE_SEL     12'h00c
`define SGW_OFF_STRAP        12'h010
`define SGW_OFF_CTRL         12'h014
`define SGW_OFF_IRQ_STAT     12'h018
`define SGW_OFF_IRQ_MASK     12'h01c

// ****************************************
// field positions
// ****************************************
`define SGW_CTRL_L2_BIT      0
`define SGW_CTRL_WAKE_CLR    1
`define SGW_IRQ_RING_BIT     0
`define SGW_IRQ_WAKE_BIT     1
`define SGW_IRQ_W            2

// ****************************************
// reset values
// ****************************************
`define SGW_RST_GPIO_OUT     8'h00
`define SGW_RST_GPIO_OE      8'h00
`define SGW_RST_MODE_SEL     16'h0000
`define SGW_RST_IRQ          2'h0

// ****************************************
// strap settle time before capture
// ****************************************
`define SGW_CLK_MHZ          125
`define SGW_STRAP_SETTLE_NS  64
`define SGW_STRAP_SETTLE_CYC ((`SGW_STRAP_SETTLE_NS * `SGW_CLK_MHZ + 999) / 1000)

`endif

// [hdl/sgw_pkg.sv]
/*
  types shared by the strap, pin and wake block.
  assumes: nothing.
*/
package sgw_pkg;

  typedef enum logic [1:0] {
    SGW_ST_SETTLE = 2'b00,
    SGW_ST_CAPT   = 2'b01,
    SGW_ST_RUN    = 2'b10
  } sgw_state_type;

  typedef enum logic [1:0] {
    SGW_AX_IDLE = 2'b00,
    SGW_AX_RESP = 2'b01
  } sgw_axi_state_type;

endpackage

// [hdl/sgw_strap_gpio_wake.sv]
/*
  strap capture, transceiver mode select buses, general-purpose pins
  and ring wake request, with an axi4-lite register slave.
  assumes: one 125 MHz clock; pins are asynchronous and resolved by
  the pad ring from the output enables; board straps are stable while
  i_reset_n is low and for a short while after its release.
*/
// Notes on behaviour
// - four 4-bit transceiver mode select output buses
// - channel 0 bus straps current, drive, test
// - channel 1 bus straps equalization and current
// - eight pins, direction from enable register
// - pin 7 strap selects eeprom organization
// - pins 6:5 rx, 4:3 tx termination
// - pins 2:0 strap equalization bits 3:1
// - wake low on ring indicate in L2
`timescale 1ns/1ps
`include "sgw_consts.svh"
module sgw_strap_gpio_wake
  import sgw_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // axi4-lite slave
  input  wire logic [11:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [11:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // transceiver mode select buses, shared with straps on chan 0/1
  input  wire logic [3:0]  i_chan0_xcvr_mode_sel,
  input  wire logic [3:0]  i_chan1_xcvr_mode_sel,
  output logic [3:0]       o_chan0_xcvr_mode_sel,
  output logic [3:0]       o_chan1_xcvr_mode_sel,
  output logic [3:0]       o_chan2_xcvr_mode_sel,
  output logic [3:0]       o_chan3_xcvr_mode_sel,
  output logic [1:0]       o_mode_sel_oe,
  // general-purpose pins
  input  wire logic [7:0]  i_gpio,
  output logic [7:0]       o_gpio,
  output logic [7:0]       o_gpio_oe,
  // ring indication and host link power state
  input  wire logic        i_ring_indicate_n,
  input  wire logic        i_link_in_l2,
  // captured straps
  output logic [3:0]       o_tx_current_level,
  output logic [3:0]       o_equalization_level,
  output logic             o_low_drive_strap,
  output logic             o_high_drive_strap,
  output logic             o_phy_test_strap,
  output logic             o_eeprom_word_org_strap,
  output logic [1:0]       o_rx_termination_adjust,
  output logic [1:0]       o_tx_termination_adjust,
  output logic             o_straps_valid,
  // wake and interrupt
  output logic             o_wake_n,
  output logic             o_irq
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] m0_sync;
  logic [3:0] m1_sync;
  logic [7:0] gpio_sync;
  logic [1:0] misc_sync;

  sgw_sync2 #(.W(4)) u_sync_m0 (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_chan0_xcvr_mode_sel),
    .o_sync    (m0_sync)
  );
  sgw_sync2 #(.W(4)) u_sync_m1 (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_chan1_xcvr_mode_sel),
    .o_sync    (m1_sync)
  );
  sgw_sync2 #(.W(8)) u_sync_gpio (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_gpio),
    .o_sync    (gpio_sync)
  );
  sgw_sync2 #(.W(2)) u_sync_misc (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   ({i_link_in_l2, i_ring_indicate_n}),
    .o_sync    (misc_sync)
  );

  // ****************************************
  // strap capture sequencer
  // ****************************************
  localparam logic [3:0] SETTLE_CYC = 4'(`SGW_STRAP_SETTLE_CYC);

  sgw_state_type state_ff;
  logic [3:0]    settle_cnt_ff;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff      <= SGW_ST_SETTLE;
      settle_cnt_ff <= 4'h0;
    end else begin
      unique case (state_ff)
        SGW_ST_SETTLE: begin
          if (settle_cnt_ff == SETTLE_CYC - 4'h1) begin
            state_ff <= SGW_ST_CAPT;
          end else begin
            settle_cnt_ff <= settle_cnt_ff + 4'h1;
          end
        end
        SGW_ST_CAPT: begin
          state_ff <= SGW_ST_RUN;
        end
        SGW_ST_RUN: begin
          state_ff <= SGW_ST_RUN;
        end
        default: begin
          state_ff <= SGW_ST_SETTLE;
        end
      endcase
    end
  end

  // capture happens once, then straps stay frozen
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_tx_current_level      <= 4'h0;
      o_equalization_level    <= 4'h8;
      o_low_drive_strap       <= 1'b0;
      o_high_drive_strap      <= 1'b0;
      o_phy_test_strap        <= 1'b0;
      o_eeprom_word_org_strap <= 1'b0;
      o_rx_termination_adjust <= 2'h0;
      o_tx_termination_adjust <= 2'h0;
      o_straps_valid          <= 1'b0;
    end else if (state_ff == SGW_ST_CAPT) begin
      o_tx_current_level      <= {m1_sync[2:0], m0_sync[3]};
      o_low_drive_strap       <= m0_sync[2];
      o_phy_test_strap        <= m0_sync[1];
      o_high_drive_strap      <= m0_sync[0];
      o_equalization_level    <= {gpio_sync[2:0], m1_sync[3]};
      o_eeprom_word_org_strap <= gpio_sync[7];
      o_rx_termination_adjust <= gpio_sync[6:5];
      o_tx_termination_adjust <= gpio_sync[4:3];
      o_straps_valid          <= 1'b1;
    end
  end

  wire run = (state_ff == SGW_ST_RUN);

  // ****************************************
  // software registers
  // ****************************************
  logic [7:0]  gpio_out_ff;
  logic [7:0]  gpio_oe_ff;
  logic [15:0] mode_sel_ff;
  logic        l2_sw_ff;
  logic [1:0]  irq_stat_ff;
  logic [1:0]  irq_mask_ff;

  sgw_axi_state_type wr_st_ff;
  sgw_axi_state_type rd_st_ff;
  logic [11:0]       awaddr_ff;
  logic              aw_got_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              w_got_ff;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `SGW_OFF_IRQ_MASK);
  endfunction

  // write channel: address and data taken in either order
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_st_ff  <= SGW_AX_IDLE;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= 2'b00;
      awaddr_ff <= 12'h000;
      aw_got_ff <= 1'b0;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      w_got_ff  <= 1'b0;
    end else begin
      unique case (wr_st_ff)
        SGW_AX_IDLE: begin
          o_awready <= !aw_got_ff && !(i_awvalid && o_awready);
          o_wready  <= !w_got_ff && !(i_wvalid && o_wready);
          if (i_awvalid && o_awready) begin
            awaddr_ff <= i_awaddr;
            aw_got_ff <= 1'b1;
          end
          if (i_wvalid && o_wready) begin
            wdata_ff <= i_wdata;
            wstrb_ff <= i_wstrb;
            w_got_ff <= 1'b1;
          end
          if (aw_got_ff && w_got_ff) begin
            o_bvalid  <= 1'b1;
            o_bresp   <= mapped(awaddr_ff) ? 2'b00 : 2'b10;
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            wr_st_ff  <= SGW_AX_RESP;
          end
        end
        SGW_AX_RESP: begin
          if (i_bready) begin
            o_bvalid  <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            wr_st_ff  <= SGW_AX_IDLE;
          end
        end
        default: begin
          wr_st_ff <= SGW_AX_IDLE;
        end
      endcase
    end
  end

  wire wr_do = (wr_st_ff == SGW_AX_IDLE) && aw_got_ff && w_got_ff;
  wire wr_lo = wr_do && wstrb_ff[0];
  wire wr_hi = wr_do && wstrb_ff[1];

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gpio_out_ff <= `SGW_RST_GPIO_OUT;
      gpio_oe_ff  <= `SGW_RST_GPIO_OE;
      mode_sel_ff <= `SGW_RST_MODE_SEL;
      l2_sw_ff    <= 1'b0;
      irq_mask_ff <= `SGW_RST_IRQ;
    end else if (wr_lo) begin
      unique case (awaddr_ff)
        `SGW_OFF_GPIO_OUT: gpio_out_ff <= wdata_ff[7:0];
        `SGW_OFF_GPIO_OE:  gpio_oe_ff  <= wdata_ff[7:0];
        `SGW_OFF_MODE_SEL: mode_sel_ff[7:0] <= wdata_ff[7:0];
        `SGW_OFF_CTRL:     l2_sw_ff <= wdata_ff[`SGW_CTRL_L2_BIT];
        `SGW_OFF_IRQ_MASK: irq_mask_ff <= wdata_ff[`SGW_IRQ_W-1:0];
        default: begin
        end
      endcase
      if (wr_hi && awaddr_ff == `SGW_OFF_MODE_SEL) begin
        mode_sel_ff[15:8] <= wdata_ff[15:8];
      end
    end else if (wr_hi && awaddr_ff == `SGW_OFF_MODE_SEL) begin
      mode_sel_ff[15:8] <= wdata_ff[15:8];
    end
  end

  // ****************************************
  // ring detect and wake request
  // ****************************************
  logic ring_prev_ff;
  wire  ring_now  = !misc_sync[0];
  wire  in_l2     = misc_sync[1] || l2_sw_ff;
  wire  ring_rise = run && ring_now && !ring_prev_ff;
  wire  wake_set  = run && ring_now && in_l2;
  wire  wake_clr  = wr_lo && awaddr_ff == `SGW_OFF_CTRL && wdata_ff[`SGW_CTRL_WAKE_CLR];
  wire  stat_w1c  = wr_lo && awaddr_ff == `SGW_OFF_IRQ_STAT;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ring_prev_ff <= 1'b0;
    end else begin
      ring_prev_ff <= ring_now;
    end
  end

  // wake stays low until software clears it or L2 is left; a ring in L2 wins
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wake_n <= 1'b1;
    end else if (wake_set) begin
      o_wake_n <= 1'b0;
    end else if (wake_clr || !in_l2) begin
      o_wake_n <= 1'b1;
    end
  end

  logic [1:0] irq_ev;
  assign irq_ev = {wake_set && o_wake_n, ring_rise};

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_stat_ff <= `SGW_RST_IRQ;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~(stat_w1c ? wdata_ff[1:0] : 2'b00)) | irq_ev;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  // shared pins stay released until straps are captured
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_chan0_xcvr_mode_sel <= 4'h0;
      o_chan1_xcvr_mode_sel <= 4'h0;
      o_chan2_xcvr_mode_sel <= 4'h0;
      o_chan3_xcvr_mode_sel <= 4'h0;
      o_mode_sel_oe         <= 2'b00;
      o_gpio                <= 8'h00;
      o_gpio_oe             <= 8'h00;
    end else begin
      o_chan0_xcvr_mode_sel <= mode_sel_ff[3:0];
      o_chan1_xcvr_mode_sel <= mode_sel_ff[7:4];
      o_chan2_xcvr_mode_sel <= mode_sel_ff[11:8];
      o_chan3_xcvr_mode_sel <= mode_sel_ff[15:12];
      o_mode_sel_oe         <= {2{run}};
      o_gpio                <= gpio_out_ff;
      o_gpio_oe             <= run ? gpio_oe_ff : 8'h00;
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_st_ff  <= SGW_AX_IDLE;
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= 2'b00;
    end else begin
      unique case (rd_st_ff)
        SGW_AX_IDLE: begin
          o_arready <= !(i_arvalid && o_arready);
          if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rresp  <= mapped(i_araddr) ? 2'b00 : 2'b10;
            rd_st_ff <= SGW_AX_RESP;
            unique case (i_araddr)
              `SGW_OFF_GPIO_OUT: o_rdata <= {24'h0, gpio_out_ff};
              `SGW_OFF_GPIO_OE:  o_rdata <= {24'h0, gpio_oe_ff};
              `SGW_OFF_GPIO_IN:  o_rdata <= {24'h0, gpio_sync};
              `SGW_OFF_MODE_SEL: o_rdata <= {16'h0, mode_sel_ff};
              `SGW_OFF_STRAP:    o_rdata <= {15'h0, o_straps_valid,
                                   o_tx_termination_adjust, o_rx_termination_adjust,
                                   o_eeprom_word_org_strap, o_high_drive_strap,
                                   o_phy_test_strap, o_low_drive_strap,
                                   o_equalization_level, o_tx_current_level};
              `SGW_OFF_CTRL:     o_rdata <= {29'h0, ring_now, !o_wake_n, l2_sw_ff};
              `SGW_OFF_IRQ_STAT: o_rdata <= {30'h0, irq_stat_ff};
              `SGW_OFF_IRQ_MASK: o_rdata <= {30'h0, irq_mask_ff};
              default:           o_rdata <= 32'h0000_0000;
            endcase
          end
        end
        SGW_AX_RESP: begin
          o_arready <= 1'b0;
          if (i_rready) begin
            o_rvalid <= 1'b0;
            rd_st_ff <= SGW_AX_IDLE;
          end
        end
        default: begin
          rd_st_ff <= SGW_AX_IDLE;
        end
      endcase
    end
  end

endmodule // sgw_strap_gpio_wake

// [hdl/sgw_sync2.sv]
/*
  two flip-flop synchroniser for a bus of levels.
  assumes: input is asynchronous to i_clk.
*/
`timescale 1ns/1ps
module sgw_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule // sgw_sync2
